// ===== cctc_pkg.sv
`default_nettype none
package cctc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IOS = 8'h80;
  localparam logic [7:0] IDX_MASK = 8'h82;
  localparam logic [7:0] IDX_DATA = 8'h83;
  localparam logic [7:0] IDX_COUNT = 8'h84;
  localparam logic [7:0] IDX_COUNT_LO = 8'h85;
  localparam logic [7:0] IDX_TIMER_SYSTEM_CONTROL = 8'h86;
  localparam logic [7:0] IDX_OUTC_HI = 8'h88;
  localparam logic [7:0] IDX_OUTC_LO = 8'h89;
  localparam logic [7:0] IDX_EDGE_HI = 8'h8A;
  localparam logic [7:0] IDX_EDGE_LO = 8'h8B;
  localparam logic [7:0] IDX_CHANNEL_IRQ_MASK = 8'h8C;
  localparam logic [7:0] IDX_OVERFLOW_PRESCALE_CONTROL = 8'h8D;
  localparam logic [7:0] IDX_FLG1 = 8'h8E;
  localparam logic [7:0] IDX_FLG2 = 8'h8F;
  localparam logic [3:0] IDX_CH_NIBBLE = 4'h9;
  localparam logic [7:0] IDX_ACC_A_HI = 8'hA2;
  localparam logic [7:0] IDX_ACC_A_LO = 8'hA3;
  localparam logic [7:0] IDX_ACC_B_HI = 8'hA4;
  localparam logic [7:0] IDX_ACC_B_LO = 8'hA5;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Field positions
  localparam int TIMER_SYSTEM_CONTROL_RUN_BIT = 7;
  localparam int TIMER_SYSTEM_CONTROL_WAIT_BIT = 6;
  localparam int TIMER_SYSTEM_CONTROL_BG_BIT = 5;
  localparam int TIMER_SYSTEM_CONTROL_FFC_BIT = 4;
  localparam int OVERFLOW_PRESCALE_CONTROL_TOI_BIT = 7;
  localparam int OVERFLOW_PRESCALE_CONTROL_CRE_BIT = 3;
  localparam int FLG2_TOF_BIT = 7;

  // Reset values and count maximum
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Prescaler shape
  localparam int PRE_W = 7;
  localparam logic [5:0] DIV64_ALL_ONES = 6'h3F;

  // Output action on successful compare, {mode, level}
  typedef enum logic [1:0] {
    cctc_act_none = 2'b00,
    cctc_act_toggle = 2'b01,
    cctc_act_low = 2'b10,
    cctc_act_high = 2'b11
  } cctc_act_t;

  // Capture edge select, {high, low}
  typedef enum logic [1:0] {
    cctc_edge_off = 2'b00,
    cctc_edge_rise = 2'b01,
    cctc_edge_fall = 2'b10,
    cctc_edge_any = 2'b11
  } cctc_edge_t;

endpackage : cctc_pkg
`default_nettype wire

// ===== cctc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module cctc_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] prescale_select,
  output logic tick,
  output logic div64_tick
);

  typedef struct packed {
    logic [cctc_pkg::PRE_W-1:0] cnt;
    logic [2:0] sel;
  } cctc_pre_state_t;

  cctc_pre_state_t s_ff;
  cctc_pre_state_t nxt_s;
  logic [cctc_pkg::PRE_W-1:0] stage_mask;

  // Stages below the active select must all be ones for a tick
  assign stage_mask = cctc_pkg::PRE_W'((8'h01 << s_ff.sel) - 8'h01);
  assign tick = run && ((s_ff.cnt & stage_mask) == stage_mask);
  // Pulse accumulator clock dies with the prescaler
  assign div64_tick = run && (s_ff.cnt[5:0] == cctc_pkg::DIV64_ALL_ONES);

  // Count only while running; new factor picked up at all-zero stages
  always_comb begin
    nxt_s = s_ff;
    if (run) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
    if (s_ff.cnt == '0) begin
      nxt_s.sel = prescale_select;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  a_sel_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.sel != $past(s_ff.sel)) |-> ($past(s_ff.cnt) == '0))
    else $error("prescale factor changed off a zero stage");

endmodule : cctc_prescaler
`default_nettype wire

// ===== cctc_port_out.sv
`timescale 1ns/1ps
`default_nettype none
module cctc_port_out #(
  parameter int NUM_CH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_CH-1:0] cmp_hit,
  input wire logic [NUM_CH-1:0] output_mode_bit,
  input wire logic [NUM_CH-1:0] output_level_bit,
  input wire logic [NUM_CH-1:0] ch7_compare_mask,
  input wire logic [NUM_CH-1:0] ch7_compare_data,
  input wire logic [NUM_CH-1:0] channel_direction_select,
  input wire logic [NUM_CH-1:0] port_direction_bits,
  input wire logic [NUM_CH-1:0] timer_port_data,
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe
);

  typedef struct packed {
    logic [NUM_CH-1:0] latch;
  } cctc_po_state_t;

  cctc_po_state_t s_ff;
  cctc_po_state_t nxt_s;
  logic [NUM_CH-1:0] timer_owns;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pin
      // Mode or level forces output; mask does on compare channels
      assign timer_owns[g] = output_mode_bit[g] || output_level_bit[g] ||
        (ch7_compare_mask[g] && channel_direction_select[g]);
      assign pin_oe[g] = timer_owns[g] || port_direction_bits[g];
      // Port data latch only reaches the pin when the timer lets go
      assign pin_out[g] = timer_owns[g] ? s_ff.latch[g] : timer_port_data[g];
    end
  endgenerate

  // Channel 7 mask wins over the pin's own action in the same cycle
  always_comb begin
    nxt_s = s_ff;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cmp_hit[NUM_CH-1] && ch7_compare_mask[i]) begin
        nxt_s.latch[i] = ch7_compare_data[i];
      end else if (cmp_hit[i] && !ch7_compare_mask[i]) begin
        case (cctc_pkg::cctc_act_t'({output_mode_bit[i],
                                    output_level_bit[i]}))
          cctc_pkg::cctc_act_toggle: nxt_s.latch[i] = !s_ff.latch[i];
          cctc_pkg::cctc_act_low: nxt_s.latch[i] = 1'b0;
          cctc_pkg::cctc_act_high: nxt_s.latch[i] = 1'b1;
          default: nxt_s.latch[i] = s_ff.latch[i];
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  a_mask_data: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit[NUM_CH-1] |=>
      (((s_ff.latch ^ $past(ch7_compare_data)) & $past(ch7_compare_mask))
       == '0))
    else $error("masked pin did not take channel 7 data");

  a_mask_blocks: assert property (@(posedge pclk)
    disable iff (!presetn)
    !cmp_hit[NUM_CH-1] |=>
      (((s_ff.latch ^ $past(s_ff.latch)) & $past(ch7_compare_mask))
       == '0))
    else $error("masked pin moved by its own compare");

  a_force_out: assert property (@(posedge pclk) disable iff (!presetn)
    ((output_mode_bit | output_level_bit) & ~pin_oe) == '0)
    else $error("configured compare pin not driven");

endmodule : cctc_port_out
`default_nettype wire

// ===== cctc_core.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cctc_core #(
  parameter int NUM_CH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode_indicator_n,
  input wire logic wait_mode,
  input wire logic background_mode,
  input wire logic [NUM_CH-1:0] timer_pin_in,
  input wire logic [NUM_CH-1:0] port_direction_bits,
  input wire logic [NUM_CH-1:0] timer_port_data,
  output logic [NUM_CH-1:0] timer_pin_out,
  output logic [NUM_CH-1:0] timer_pin_oe,
  output logic [NUM_CH-1:0] channel_irq,
  output logic overflow_irq,
  output logic accum_clk_tick,
  output logic module_halt,
  output logic modcnt_halt,
  output logic accum_a_clear,
  output logic accum_b_clear
);

  typedef struct packed {
    logic [NUM_CH-1:0] ios;
    logic [NUM_CH-1:0] mask;
    logic [NUM_CH-1:0] data;
    logic [7:0] timer_system_control;
    logic [2*NUM_CH-1:0] out_ctl;
    logic [2*NUM_CH-1:0] edge_ctl;
    logic [NUM_CH-1:0] irq_en;
    logic [7:0] overflow_prescale_control;
    logic [15:0] count;
    logic [NUM_CH-1:0] flags;
    logic overflow_flag;
    logic [NUM_CH-1:0][15:0] chval;
    logic [NUM_CH-1:0] sync1;
    logic [NUM_CH-1:0] sync2;
    logic [NUM_CH-1:0] prev;
    logic [31:0] rdata;
    logic slverr;
  } cctc_core_state_t;

  cctc_core_state_t s_ff;
  cctc_core_state_t nxt_s;

  logic [7:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic setup;
  logic is_ch;
  logic [2:0] ch;
  logic run;
  logic tick;
  logic ffc;
  logic cre;
  logic ch7_reset;
  logic ovf_set;
  logic clr_tof;
  logic count_wr;
  logic [NUM_CH-1:0] cmp_hit;
  logic [NUM_CH-1:0] edge_hit;
  logic [NUM_CH-1:0] clr_ch;
  logic [NUM_CH-1:0] om;
  logic [NUM_CH-1:0] ol;
  logic [31:0] rmux;
  logic mapped;

  // APB decode; zero-wait slave, read data sampled in the setup cycle
  assign idx = paddr[cctc_pkg::IDX_MSB:cctc_pkg::IDX_LSB];
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign is_ch = (idx[7:4] == cctc_pkg::IDX_CH_NIBBLE);
  assign ch = idx[3:1];
  assign pready = 1'b1;
  assign prdata = s_ff.rdata;
  assign pslverr = acc && s_ff.slverr;

  // Halting: wait stops everything, background stops counter and accumulator clock but spares captures
  assign module_halt = s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_WAIT_BIT] && wait_mode;
  assign modcnt_halt = module_halt ||
    (s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_BG_BIT] && background_mode);
  assign run = s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_RUN_BIT] && !modcnt_halt;
  assign ffc = s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_FFC_BIT];
  assign cre = s_ff.overflow_prescale_control[cctc_pkg::OVERFLOW_PRESCALE_CONTROL_CRE_BIT];

  cctc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .prescale_select(s_ff.overflow_prescale_control[2:0]),
    .tick(tick),
    .div64_tick(accum_clk_tick)
  );

  // Per-channel compare match, capture edge and interrupt gating
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic rise;
      logic fall;
      assign om[g] = s_ff.out_ctl[2*g+1];
      assign ol[g] = s_ff.out_ctl[2*g];
      assign rise = s_ff.sync2[g] && !s_ff.prev[g];
      assign fall = !s_ff.sync2[g] && s_ff.prev[g];
      // Match is taken once per count value, on the advancing tick
      assign cmp_hit[g] = tick && s_ff.ios[g] &&
        (s_ff.count == s_ff.chval[g]);
      always_comb begin
        case (cctc_pkg::cctc_edge_t'(s_ff.edge_ctl[2*g+1 -: 2]))
          cctc_pkg::cctc_edge_rise: edge_hit[g] = rise;
          cctc_pkg::cctc_edge_fall: edge_hit[g] = fall;
          cctc_pkg::cctc_edge_any: edge_hit[g] = rise || fall;
          default: edge_hit[g] = 1'b0;
        endcase
        if (s_ff.ios[g] || module_halt) begin
          edge_hit[g] = 1'b0;
        end
      end
      assign channel_irq[g] = s_ff.flags[g] && s_ff.irq_en[g];
    end
  endgenerate

  assign overflow_irq = s_ff.overflow_flag &&
    s_ff.overflow_prescale_control[cctc_pkg::OVERFLOW_PRESCALE_CONTROL_TOI_BIT];

  cctc_port_out #(
    .NUM_CH(NUM_CH)
  ) u_port (
    .pclk(pclk),
    .presetn(presetn),
    .cmp_hit(cmp_hit),
    .output_mode_bit(om),
    .output_level_bit(ol),
    .ch7_compare_mask(s_ff.mask),
    .ch7_compare_data(s_ff.data),
    .channel_direction_select(s_ff.ios),
    .port_direction_bits(port_direction_bits),
    .timer_port_data(timer_port_data),
    .pin_out(timer_pin_out),
    .pin_oe(timer_pin_oe)
  );

  // Counter events; a reset by channel 7 is not a wrap
  assign ch7_reset = cre && cmp_hit[NUM_CH-1];
  assign ovf_set = tick && !ch7_reset &&
    (s_ff.count == cctc_pkg::COUNT_MAX);
  assign count_wr = wr && (idx == cctc_pkg::IDX_COUNT) &&
    !special_mode_indicator_n;

  // Flag clears: write-one-to-clear plus the fast-clear side effects
  always_comb begin
    clr_ch = '0;
    if (wr && (idx == cctc_pkg::IDX_FLG1)) begin
      clr_ch = pwdata[NUM_CH-1:0];
    end
    if (ffc && is_ch && ((rd && !s_ff.ios[ch]) || (wr && s_ff.ios[ch]))) begin
      clr_ch[ch] = 1'b1;
    end
  end

  assign clr_tof = (wr && (idx == cctc_pkg::IDX_FLG2) &&
    pwdata[cctc_pkg::FLG2_TOF_BIT]) || (ffc && acc &&
    ((idx == cctc_pkg::IDX_COUNT) || (idx == cctc_pkg::IDX_COUNT_LO)));
  // Accumulators live outside; they see a one-cycle clear strobe
  assign accum_a_clear = ffc && acc && ((idx == cctc_pkg::IDX_ACC_A_HI) ||
    (idx == cctc_pkg::IDX_ACC_A_LO));
  assign accum_b_clear = ffc && acc && ((idx == cctc_pkg::IDX_ACC_B_HI) ||
    (idx == cctc_pkg::IDX_ACC_B_LO));

  // Read mux; count is returned whole so bytes never tear
  always_comb begin
    rmux = '0;
    mapped = 1'b1;
    if (is_ch) begin
      rmux[15:0] = s_ff.chval[ch];
    end else begin
      case (idx)
        cctc_pkg::IDX_IOS: rmux[NUM_CH-1:0] = s_ff.ios;
        cctc_pkg::IDX_MASK: rmux[NUM_CH-1:0] = s_ff.mask;
        cctc_pkg::IDX_DATA: rmux[NUM_CH-1:0] = s_ff.data;
        cctc_pkg::IDX_COUNT: rmux[15:0] = s_ff.count;
        cctc_pkg::IDX_COUNT_LO: rmux = '0;
        cctc_pkg::IDX_TIMER_SYSTEM_CONTROL: rmux[7:0] = s_ff.timer_system_control;
        cctc_pkg::IDX_OUTC_HI: rmux[7:0] = s_ff.out_ctl[15:8];
        cctc_pkg::IDX_OUTC_LO: rmux[7:0] = s_ff.out_ctl[7:0];
        cctc_pkg::IDX_EDGE_HI: rmux[7:0] = s_ff.edge_ctl[15:8];
        cctc_pkg::IDX_EDGE_LO: rmux[7:0] = s_ff.edge_ctl[7:0];
        cctc_pkg::IDX_CHANNEL_IRQ_MASK: rmux[NUM_CH-1:0] = s_ff.irq_en;
        cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL: rmux[7:0] = s_ff.overflow_prescale_control;
        cctc_pkg::IDX_FLG1: rmux[NUM_CH-1:0] = s_ff.flags;
        cctc_pkg::IDX_FLG2: rmux[cctc_pkg::FLG2_TOF_BIT] = s_ff.overflow_flag;
        cctc_pkg::IDX_ACC_A_HI, cctc_pkg::IDX_ACC_A_LO,
        cctc_pkg::IDX_ACC_B_HI, cctc_pkg::IDX_ACC_B_LO: rmux = '0;
        default: mapped = 1'b0;
      endcase
    end
  end

  // Next state of the whole core
  always_comb begin
    nxt_s = s_ff;
    // Pins pass two flops before the edge detector sees them
    nxt_s.sync1 = timer_pin_in;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.prev = s_ff.sync2;
    if (setup) begin
      nxt_s.rdata = rmux;
      nxt_s.slverr = !mapped;
    end
    if (tick) begin
      if (ch7_reset) begin
        nxt_s.count = cctc_pkg::RST_WORD;
      end else begin
        nxt_s.count = s_ff.count + 16'h0001;
      end
    end
    if (wr) begin
      case (idx)
        cctc_pkg::IDX_IOS: nxt_s.ios = pwdata[NUM_CH-1:0];
        cctc_pkg::IDX_MASK: nxt_s.mask = pwdata[NUM_CH-1:0];
        cctc_pkg::IDX_DATA: nxt_s.data = pwdata[NUM_CH-1:0];
        cctc_pkg::IDX_TIMER_SYSTEM_CONTROL: nxt_s.timer_system_control = pwdata[7:0];
        cctc_pkg::IDX_OUTC_HI: nxt_s.out_ctl[15:8] = pwdata[7:0];
        cctc_pkg::IDX_OUTC_LO: nxt_s.out_ctl[7:0] = pwdata[7:0];
        cctc_pkg::IDX_EDGE_HI: nxt_s.edge_ctl[15:8] = pwdata[7:0];
        cctc_pkg::IDX_EDGE_LO: nxt_s.edge_ctl[7:0] = pwdata[7:0];
        cctc_pkg::IDX_CHANNEL_IRQ_MASK: nxt_s.irq_en = pwdata[NUM_CH-1:0];
        cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL: nxt_s.overflow_prescale_control = pwdata[7:0];
        default: nxt_s.ios = s_ff.ios;
      endcase
      // Compare value writes have no effect on capture channels
      if (is_ch && s_ff.ios[ch]) begin
        nxt_s.chval[ch] = pwdata[15:0];
      end
    end
    if (count_wr) begin
      nxt_s.count = pwdata[15:0];
    end
    // Capture takes the count; a pin edge beats a same-cycle write
    for (int i = 0; i < NUM_CH; i++) begin
      if (edge_hit[i]) begin
        nxt_s.chval[i] = s_ff.count;
      end
    end
    // Set wins over clear for every flag
    nxt_s.flags = (s_ff.flags & ~clr_ch) | cmp_hit | edge_hit;
    nxt_s.overflow_flag = (s_ff.overflow_flag && !clr_tof) || ovf_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  a_count_step: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && !ch7_reset && !count_wr) |=>
      (s_ff.count == $past(s_ff.count) + 16'h0001))
    else $error("count did not advance on tick");

  a_count_stop: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_RUN_BIT] && !count_wr) |=>
      (s_ff.count == $past(s_ff.count)) && !$past(accum_clk_tick))
    else $error("count moved while timer disabled");

  a_ch7_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (ch7_reset && !count_wr) |=> (s_ff.count == 16'h0000))
    else $error("channel 7 compare did not reset count");

  a_tof_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !ch7_reset && (s_ff.count == 16'hFFFF)) |=>
      s_ff.overflow_flag && (s_ff.count == 16'h0000 || $past(count_wr)))
    else $error("wrap did not set overflow");

  a_tof_noset: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_ff.overflow_flag && !(tick && s_ff.count == 16'hFFFF)) |=> !s_ff.overflow_flag)
    else $error("overflow set without a wrap");

  a_tof_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == cctc_pkg::IDX_FLG2 && pwdata[cctc_pkg::FLG2_TOF_BIT]
     && !ovf_set) |=> !s_ff.overflow_flag)
    else $error("write one did not clear overflow");

  a_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == cctc_pkg::IDX_FLG1 && pwdata[NUM_CH-1:0] == '0) |=>
      ((s_ff.flags & $past(s_ff.flags)) == $past(s_ff.flags)))
    else $error("write zero disturbed a channel flag");

  a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == cctc_pkg::IDX_COUNT && special_mode_indicator_n &&
     !tick) |=> (s_ff.count == $past(s_ff.count)))
    else $error("count loaded in normal mode");

  a_fast_tof: assert property (@(posedge pclk) disable iff (!presetn)
    (ffc && acc && idx == cctc_pkg::IDX_COUNT && !ovf_set) |=> !s_ff.overflow_flag)
    else $error("count access did not clear overflow");

  a_wait_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_WAIT_BIT] && wait_mode) |->
      (!tick && !accum_clk_tick && module_halt && modcnt_halt))
    else $error("timer ran during wait halt");

  a_bg_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.timer_system_control[cctc_pkg::TIMER_SYSTEM_CONTROL_BG_BIT] && background_mode && !wait_mode) |->
      (!tick && modcnt_halt && !module_halt))
    else $error("background halt wrong");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == cctc_pkg::IDX_CHANNEL_IRQ_MASK && pwdata[NUM_CH-1:0] == '0) |=>
      (channel_irq == '0))
    else $error("channel interrupt without enable");

endmodule : cctc_core
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); \
  end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, smin_n, wm, bm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ra;
  logic pready, pslverr, er, oirq, atick, mh, mch, aca, acb;
  logic [7:0] pin, ddr, pdat, pout, poe, cirq;
  logic [1:0] ac;
  int failures, check_count, cyc;

  cctc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode_indicator_n(smin_n), .wait_mode(wm),
    .background_mode(bm), .timer_pin_in(pin), .port_direction_bits(ddr),
    .timer_port_data(pdat), .timer_pin_out(pout), .timer_pin_oe(poe),
    .channel_irq(cirq), .overflow_irq(oirq), .accum_clk_tick(atick),
    .module_halt(mh), .modcnt_halt(mch), .accum_a_clear(aca),
    .accum_b_clear(acb));

  // Clock; the run is short, so a fixed ceiling cuts any hang
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // One APB transfer; the answer is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    ac = {aca, acb};
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following setup never reassigns psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdr(input logic [7:0] idx);
    apb(1'b0, idx, 32'h00000000);
  endtask : rdr

  task automatic t_count();
    rdr(cctc_pkg::IDX_COUNT);
    `CHK(rd[15:0], 16'h0000)
    rdr(8'h81);
    `CHK(er, 1'b1)
    rdr(cctc_pkg::IDX_ACC_A_HI);
    `CHK(ac, 2'b00)
    wr(cctc_pkg::IDX_COUNT, 32'h00001234);
    rdr(cctc_pkg::IDX_COUNT);
    `CHK(rd[15:0], 16'h0000)
    smin_n <= 1'b0;
    wr(cctc_pkg::IDX_COUNT, 32'h00001234);
    smin_n <= 1'b1;
    rdr(cctc_pkg::IDX_COUNT);
    `CHK(rd[15:0], 16'h1234)
  endtask : t_count

  // Two reads 22 edges apart; prescale 8 gives 20 counts per 160 edges
  task automatic t_run();
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000080);
    rdr(cctc_pkg::IDX_COUNT);
    ra = rd;
    repeat (19) @(posedge pclk);
    rdr(cctc_pkg::IDX_COUNT);
    `CHK(rd[15:0] - ra[15:0], 16'h0016)
    wr(cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL, 32'h00000003);
    repeat (300) @(posedge pclk);
    rdr(cctc_pkg::IDX_COUNT);
    ra = rd;
    repeat (157) @(posedge pclk);
    rdr(cctc_pkg::IDX_COUNT);
    `CHK((rd[15:0] - ra[15:0]) inside {[16'h13:16'h15]}, 1'b1)
    wr(cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL, 32'h00000000);
  endtask : t_run

  task automatic t_halt(input logic [7:0] ctl, input logic w,
                        input logic b, input logic exp_mh,
                        input logic exp_mch);
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, {24'h0, ctl});
    wm <= w;
    bm <= b;
    rdr(cctc_pkg::IDX_COUNT);
    ra = rd;
    repeat (100) begin
      @(posedge pclk);
      `CHK(atick === 1'b1 && ctl[7] == 1'b0, 1'b0)
    end
    rdr(cctc_pkg::IDX_COUNT);
    `CHK(rd[15:0], ra[15:0])
    `CHK(mh, exp_mh)
    `CHK(mch, exp_mch)
    wm <= 1'b0;
    bm <= 1'b0;
  endtask : t_halt

  task automatic t_ovf();
    smin_n <= 1'b0;
    wr(cctc_pkg::IDX_COUNT, 32'h0000FFF0);
    smin_n <= 1'b1;
    // Old divide-by-8 may linger until the prescaler next passes zero
    repeat (200) @(posedge pclk);
    rdr(cctc_pkg::IDX_FLG2);
    `CHK(rd[7], 1'b1)
    `CHK(oirq, 1'b0)
    wr(cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL, 32'h00000080);
    `CHK(oirq, 1'b1)
    wr(cctc_pkg::IDX_FLG2, 32'h00000000);
    rdr(cctc_pkg::IDX_FLG2);
    `CHK(rd[7], 1'b1)
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000090);
    rdr(cctc_pkg::IDX_ACC_A_HI);
    `CHK(ac, 2'b10)
    rdr(cctc_pkg::IDX_ACC_B_LO);
    `CHK(ac, 2'b01)
    rdr(cctc_pkg::IDX_COUNT);
    rdr(cctc_pkg::IDX_FLG2);
    `CHK(rd[7], 1'b0)
    wr(cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL, 32'h00000000);
  endtask : t_ovf

  // Channel 7 and 0 compare at 0x40 with count reset, then judge the pin
  task automatic t_cmp(input logic [7:0] oc, input logic [7:0] mk,
                       input logic [7:0] dt, input logic exp_pin);
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000000);
    // Start below the compare value, else the count runs the full wrap
    smin_n <= 1'b0;
    wr(cctc_pkg::IDX_COUNT, 32'h00000000);
    smin_n <= 1'b1;
    wr(cctc_pkg::IDX_OUTC_LO, {24'h0, oc});
    wr(cctc_pkg::IDX_MASK, {24'h0, mk});
    wr(cctc_pkg::IDX_DATA, {24'h0, dt});
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000080);
    repeat (200) @(posedge pclk);
    rdr(cctc_pkg::IDX_COUNT);
    `CHK(rd[15:0] <= 16'h0040, 1'b1)
    `CHK(pout[0], exp_pin)
    `CHK(poe[0], 1'b1)
    `CHK(poe[1], 1'b0)
    `CHK(cirq[7:6], 2'b10)
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000000);
    wr(cctc_pkg::IDX_FLG1, 32'h00000000);
    rdr(cctc_pkg::IDX_FLG1);
    `CHK(rd[7], 1'b1)
    wr(cctc_pkg::IDX_FLG1, 32'h000000FF);
    rdr(cctc_pkg::IDX_FLG1);
    `CHK(rd[7:0], 8'h00)
  endtask : t_cmp

  // Channel 1 captures; edge select sits in bits 3:2 of the low edge reg
  task automatic t_cap(input logic [1:0] sel, input logic lvl,
                       input logic exp_f);
    wr(cctc_pkg::IDX_EDGE_LO, {28'h0, sel, 2'b00});
    pin[1] <= lvl;
    repeat (8) @(posedge pclk);
    rdr(cctc_pkg::IDX_FLG1);
    `CHK(rd[1], exp_f)
    rdr(8'h92);
    rdr(cctc_pkg::IDX_FLG1);
    `CHK(rd[1], 1'b0)
  endtask : t_cap

  initial begin
    {psel, penable, pwrite, wm, bm} = 5'b00000;
    smin_n = 1'b1;
    presetn = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {pin, ddr, pdat} = {8'h00, 8'h00, 8'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_count();
    t_run();
    t_halt(8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    t_halt(8'hC0, 1'b1, 1'b0, 1'b1, 1'b1);
    t_halt(8'hA0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000080);
    t_ovf();
    wr(cctc_pkg::IDX_IOS, 32'h00000081);
    wr(8'h9E, 32'h00000040);
    wr(8'h90, 32'h00000040);
    wr(cctc_pkg::IDX_OVERFLOW_PRESCALE_CONTROL, 32'h00000008);
    wr(cctc_pkg::IDX_CHANNEL_IRQ_MASK, 32'h00000080);
    t_cmp(8'h03, 8'h00, 8'h00, 1'b1);
    t_cmp(8'h02, 8'h00, 8'h00, 1'b0);
    t_cmp(8'h03, 8'h01, 8'h00, 1'b0);
    t_cmp(8'h02, 8'h01, 8'h01, 1'b1);
    // Channel 0 handed back: no mode, level or mask, so the pin is let go
    wr(cctc_pkg::IDX_OUTC_LO, 32'h00000000);
    wr(cctc_pkg::IDX_MASK, 32'h00000000);
    `CHK(poe[0], 1'b0)
    wr(cctc_pkg::IDX_TIMER_SYSTEM_CONTROL, 32'h00000090);
    t_cap(2'b01, 1'b1, 1'b1);
    t_cap(2'b01, 1'b0, 1'b0);
    t_cap(2'b10, 1'b1, 1'b0);
    t_cap(2'b10, 1'b0, 1'b1);
    t_cap(2'b00, 1'b1, 1'b0);
    t_cap(2'b11, 1'b0, 1'b1);
    stop_test();
  end
endmodule : tb
`default_nettype wire
